/* verilog/awg_triangle_gen.sv */
// Auto-DAC triangle waveform generator top
`timescale 1ns/1ps

module awg_triangle_gen #(
  parameter int unsigned CW = awg_pkg::CODE_W
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Generator commands, one-cycle pulses
  input  wire logic            generatorBeginCmd,
  input  wire logic            generatorHaltCmd,
  // Generator parameters
  input  wire logic [CW-1:0]   rampUpperLimit,
  input  wire logic [CW-1:0]   rampLowerLimit,
  input  wire logic [2:0]      stepSel,
  input  wire logic [2:0]      rateSel,
  input  wire logic [1:0]      resSel,
  input  wire logic [31:0]     peakDwellTime,
  // Host DAC code path
  input  wire logic            hostCodeValid,
  input  wire logic [CW-1:0]   hostCode,
  input  wire logic            polaritySwapEnable,
  // DAC side
  output logic [CW-1:0]        dacCode,
  output logic                 dacCodeLoad,
  output logic                 chopEnable,
  output logic                 generatorActive,
  output logic                 hostCodeDropped
);

  // ==========================================================
  // Operating notes
  // ==========================================================
  // Limits and step size are frozen at the begin command, so the
  // host may stage the next set while a waveform runs.
  // The rate code is read live and should stay steady while running.
  // Each update interval is floored to whole clock cycles, so the
  // real update rate sits slightly above the nominal figure, or on it for rate codes 0 and 4.
  // The divider restarts on the begin edge: the first step comes one
  // full update interval after the lower limit is put out.
  // At a limit the code is held for one update interval plus the
  // dwell count; the divider is parked during the dwell so the two
  // add up without any turnaround cycles.
  // A zero dwell reverses on the clamping update itself.
  // Host codes that arrive while the generator runs are dropped and
  // flagged for one cycle; halt leaves the last code on the DAC.
  // Chopping is forced off for the whole run and follows the
  // request again from the cycle the generator goes idle.
  // A begin command while running is ignored; halt always wins the state, but a lower limit or ramp step due that cycle still loads.

  // ==========================================================
  // State and working registers
  // ==========================================================
  awg_pkg::awg_state_t state_reg, state_next;
  logic [CW-1:0]  code_reg, code_next;
  logic           up_reg, up_next;
  logic [31:0]    dwell_reg, dwell_next;
  logic [CW-1:0]  hi_reg, lo_reg;
  logic [CW-1:0]  step_reg;
  logic           tick;
  logic           running;

  // ==========================================================
  // Step size and next-code arithmetic
  // ==========================================================
  logic [CW-1:0]  stepBase;
  logic [CW-1:0]  stepSize;
  logic [CW:0]    sumUp;
  logic           hitTop;
  logic           hitBot;
  logic [CW-1:0]  rampCode;
  logic           limitHit;
  logic           dwellNone;
  logic [31:0]    dwellLoad;
  logic           tickRun;

  // Base step by resolution, scaled by 2^n
  assign stepBase =
    (resSel == awg_pkg::RES_16) ? CW'(awg_pkg::STEP_BASE_16) :
    (resSel == awg_pkg::RES_14) ? CW'(awg_pkg::STEP_BASE_14) :
                                  CW'(awg_pkg::STEP_BASE_18);
  assign stepSize = stepBase << stepSel;

  // Compare and clamp against the latched limits
  assign sumUp  = {1'b0, code_reg} + {1'b0, step_reg};
  assign hitTop = (sumUp >= {1'b0, hi_reg});
  assign hitBot = (code_reg < lo_reg) ||
                  ((code_reg - lo_reg) <= step_reg);
  assign rampCode = up_reg ? (hitTop ? hi_reg : sumUp[CW-1:0])
                           : (hitBot ? lo_reg : code_reg - step_reg);
  assign running  = (state_reg != awg_pkg::ST_IDLE);

  // Limit reached on this update, in the current direction
  assign limitHit  = up_reg ? hitTop : hitBot;
  // A zero dwell turns round on the clamping update itself
  assign dwellNone = (peakDwellTime == 32'h00000000);
  // Countdown start, so the hold adds exactly the dwell cycles
  assign dwellLoad = peakDwellTime - 32'h00000001;
  // Divider runs only while ramping and is parked during a dwell
  assign tickRun   = (state_next == awg_pkg::ST_RAMP);

  // Update-rate divider, parked outside the ramp state
  // Restarts on the begin edge, so the first step follows one interval on
  awg_rate_tick u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (tickRun),
    .rateSel (rateSel),
    .tick    (tick)
  );

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    up_next    = up_reg;
    dwell_next = dwell_reg;
    case (state_reg)
      // Idle: host codes pass straight to the DAC
      awg_pkg::ST_IDLE: begin
        if (generatorBeginCmd) begin
          state_next = awg_pkg::ST_RAMP;
          code_next  = rampLowerLimit;
          up_next    = 1'b1;
        end else if (hostCodeValid) begin
          code_next = hostCode;
        end
      end
      // Ramp: one step per update, clamped at the limits
      awg_pkg::ST_RAMP: begin
        if (tick) begin
          code_next = rampCode;
          if (limitHit && dwellNone) begin
            up_next = !up_reg;
          end else if (limitHit) begin
            state_next = awg_pkg::ST_DWELL;
            dwell_next = dwellLoad;
          end
        end
      end
      // Dwell: hold the code, then turn round
      awg_pkg::ST_DWELL: begin
        if (dwell_reg == 32'h00000000) begin
          state_next = awg_pkg::ST_RAMP;
          up_next    = !up_reg;
        end else begin
          dwell_next = dwell_reg - 32'h00000001;
        end
      end
      default: begin
        state_next = awg_pkg::ST_IDLE;
      end
    endcase
    // Halt wins over begin and over any state change; a begin's lower limit or a ramp step due in the same cycle still loads
    if (generatorHaltCmd) begin
      state_next = awg_pkg::ST_IDLE;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Generator state and live code
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= awg_pkg::ST_IDLE;
      code_reg  <= awg_pkg::CODE_RESET;
      up_reg    <= 1'b1;
      dwell_reg <= awg_pkg::DWELL_RESET;
    end else begin
      state_reg <= state_next;
      code_reg  <= code_next;
      up_reg    <= up_next;
      dwell_reg <= dwell_next;
    end
  end

  // Parameters captured at start, host must set them first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hi_reg   <= awg_pkg::CODE_RESET;
      lo_reg   <= awg_pkg::CODE_RESET;
      step_reg <= awg_pkg::CODE_RESET;
    end else if (state_reg == awg_pkg::ST_IDLE && generatorBeginCmd) begin
      hi_reg   <= rampUpperLimit;
      lo_reg   <= rampLowerLimit;
      step_reg <= stepSize;
    end
  end

  // Outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dacCode         <= awg_pkg::CODE_RESET;
      dacCodeLoad     <= 1'b0;
      chopEnable      <= 1'b0;
      generatorActive <= 1'b0;
      hostCodeDropped <= 1'b0;
    end else begin
      // Load marks every change of code, host or ramp
      dacCode         <= code_next;
      dacCodeLoad     <= (code_next != code_reg);
      chopEnable      <= polaritySwapEnable &&
                         (state_next == awg_pkg::ST_IDLE);
      generatorActive <= (state_next != awg_pkg::ST_IDLE);
      hostCodeDropped <= hostCodeValid && running;
    end
  end

endmodule : awg_triangle_gen

/* verilog/awg_pkg.sv */
// Package of constants and types for the auto-DAC triangle generator
package awg_pkg;

  // ==========================================================
  // Clock and update-rate timing
  // ==========================================================
  localparam int unsigned SYS_CLK_HZ = 125000000;
  localparam int unsigned RATE_HZ_0 = 4000;
  localparam int unsigned RATE_HZ_1 = 6000;
  localparam int unsigned RATE_HZ_2 = 9000;
  localparam int unsigned RATE_HZ_3 = 12000;
  localparam int unsigned RATE_HZ_4 = 40000;
  localparam int unsigned RATE_HZ_5 = 60000;
  localparam int unsigned RATE_HZ_6 = 90000;
  localparam int unsigned RATE_HZ_7 = 150000;
  // Cycles per update, rounded down (longest interval allowed)
  localparam int unsigned RATE_CYC_0 = SYS_CLK_HZ / RATE_HZ_0;
  localparam int unsigned RATE_CYC_1 = SYS_CLK_HZ / RATE_HZ_1;
  localparam int unsigned RATE_CYC_2 = SYS_CLK_HZ / RATE_HZ_2;
  localparam int unsigned RATE_CYC_3 = SYS_CLK_HZ / RATE_HZ_3;
  localparam int unsigned RATE_CYC_4 = SYS_CLK_HZ / RATE_HZ_4;
  localparam int unsigned RATE_CYC_5 = SYS_CLK_HZ / RATE_HZ_5;
  localparam int unsigned RATE_CYC_6 = SYS_CLK_HZ / RATE_HZ_6;
  localparam int unsigned RATE_CYC_7 = SYS_CLK_HZ / RATE_HZ_7;
  localparam int unsigned TICK_W = 16;

  // ==========================================================
  // Code and step layout
  // ==========================================================
  localparam int unsigned CODE_W = 24;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned STEP_BASE_18 = 1024;
  localparam int unsigned STEP_BASE_16 = 256;
  localparam int unsigned STEP_BASE_14 = 64;
  localparam logic [CODE_W-1:0] CODE_RESET = 24'h000000;
  localparam logic [31:0] DWELL_RESET = 32'h00000000;

  // Resolution selection
  typedef enum logic [1:0] {
    RES_18 = 2'h0,
    RES_16 = 2'h1,
    RES_14 = 2'h2
  } awg_res_t;

  // Generator states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RAMP,
    ST_DWELL
  } awg_state_t;

endpackage : awg_pkg

/* verilog/awg_rate_tick.sv */
// Update-rate tick divider for the generator
`timescale 1ns/1ps

module awg_rate_tick #(
  parameter int unsigned TW = awg_pkg::TICK_W
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst,
  // Control
  input  wire logic           run,
  input  wire logic [2:0]     rateSel,
  // Tick out
  output logic                tick
);

  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  logic [TW-1:0] period;
  logic          wrap;

  // Cycles per update less one for each rate code
  assign period =
    (rateSel == 3'h0) ? TW'(awg_pkg::RATE_CYC_0 - 1) :
    (rateSel == 3'h1) ? TW'(awg_pkg::RATE_CYC_1 - 1) :
    (rateSel == 3'h2) ? TW'(awg_pkg::RATE_CYC_2 - 1) :
    (rateSel == 3'h3) ? TW'(awg_pkg::RATE_CYC_3 - 1) :
    (rateSel == 3'h4) ? TW'(awg_pkg::RATE_CYC_4 - 1) :
    (rateSel == 3'h5) ? TW'(awg_pkg::RATE_CYC_5 - 1) :
    (rateSel == 3'h6) ? TW'(awg_pkg::RATE_CYC_6 - 1) :
                        TW'(awg_pkg::RATE_CYC_7 - 1);
  assign wrap     = (cnt_reg >= period);
  assign cnt_next = (!run || wrap) ? '0 : cnt_reg + TW'(1);

  // Counter held at zero whenever the generator is not ramping
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= run && wrap;
    end
  end

endmodule : awg_rate_tick

/* verif/awg_triangle_gen_sva.sv */
// Port checker for the triangle generator
`timescale 1ns/1ps
module awg_triangle_gen_sva (
  // Clock, reset, commands
  input wire logic        sys_clk, rst, generatorBeginCmd, generatorHaltCmd,
  // Limits and host path
  input wire logic [23:0] rampUpperLimit, rampLowerLimit, hostCode,
  input wire logic        hostCodeValid, polaritySwapEnable,
  // DAC side
  input wire logic [23:0] dacCode,
  input wire logic        dacCodeLoad, chopEnable, generatorActive,
  input wire logic        hostCodeDropped
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Start, run and halt
  // ==========================================================
  sequence s_start;
    generatorBeginCmd && !generatorActive && !generatorHaltCmd;
  endsequence
  start_code_a: assert property (s_start |=> generatorActive && dacCodeLoad
    && dacCode == $past(rampLowerLimit)) else $error("start code wrong");
  halt_stops_a: assert property (generatorHaltCmd |=> !generatorActive)
    else $error("halt ignored");
  keep_run_a: assert property (generatorActive && !generatorHaltCmd
    |=> generatorActive) else $error("run ended alone");
  chop_off_a: assert property (generatorActive |-> !chopEnable)
    else $error("chop on while running");
  chop_idle_a: assert property (!generatorActive && !$past(generatorActive)
    && !$past(rst) |-> chopEnable == $past(polaritySwapEnable))
    else $error("chop not following request");
  // ==========================================================
  // Host codes and range
  // ==========================================================
  drop_code_a: assert property (hostCodeValid && generatorActive
    && !generatorHaltCmd |=> hostCodeDropped) else $error("code not dropped");
  take_code_a: assert property (hostCodeValid && !generatorActive
    && !generatorBeginCmd && !generatorHaltCmd
    |=> dacCodeLoad && dacCode == $past(hostCode)) else $error("code lost");
  in_range_a: assert property (generatorActive |-> dacCode >= rampLowerLimit
    && dacCode <= rampUpperLimit) else $error("code out of limits");
  load_mark_a: assert property ($changed(dacCode) |-> dacCodeLoad)
    else $error("code change without load");
endmodule : awg_triangle_gen_sva
bind awg_triangle_gen awg_triangle_gen_sva i_awg_triangle_gen_sva (.*);

/* verif/awg_host_model.sv */
// Host model that programs and commands the generator
`timescale 1ns/1ps
module awg_host_model (
  // Clock
  input wire logic   sys_clk,
  // Commands and strobes
  output logic       beginCmd, haltCmd, codeValid,
  // Parameters and code
  output logic [23:0] upper, lower, code,
  output logic [2:0] stepSel, rateSel,
  output logic [1:0] resSel
);
  // Idle levels at time zero
  initial begin
    {beginCmd, haltCmd, codeValid} = 3'h0;
    {upper, lower, code, stepSel, rateSel, resSel} = '0;
  end
  // Parameters settle a cycle before the begin pulse
  task automatic run(input logic [23:0] lo, hi, input logic [2:0] st, rt,
                     input logic [1:0] rs);
    @(negedge sys_clk);
    lower = lo;
    upper = hi;
    stepSel = st;
    rateSel = rt;
    resSel = rs;
    @(negedge sys_clk);
    beginCmd = 1'b1;
    @(negedge sys_clk);
    beginCmd = 1'b0;
  endtask : run
  // One-cycle halt pulse
  task automatic halt();
    @(negedge sys_clk);
    haltCmd = 1'b1;
    @(negedge sys_clk);
    haltCmd = 1'b0;
  endtask : halt
  // One code strobe, data scrambled once released
  task automatic send(input logic [23:0] c);
    @(negedge sys_clk);
    code = c;
    codeValid = 1'b1;
    @(negedge sys_clk);
    codeValid = 1'b0;
    code = ~c;
  endtask : send
endmodule : awg_host_model

/* verif/awg_triangle_gen_tb.sv */
// Self-checking bench for the triangle generator
`timescale 1ns/1ps
module awg_triangle_gen_tb;
  logic        sys_clk = 1'b0, rst = 1'b1, swapReq = 1'b1;
  logic        begCmd, hltCmd, hValid, dLoad, chop, active, dropped;
  logic [23:0] upLim, loLim, hCode, dCode;
  logic [2:0]  stSel, rtSel;
  logic [1:0]  rsSel;
  logic [31:0] dwell = 32'h5;
  int          n_fail = 0, checked = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  // ==========================================================
  // Host model and design
  // ==========================================================
  awg_host_model i_awg_host_model (.sys_clk(sys_clk), .beginCmd(begCmd),
    .haltCmd(hltCmd), .codeValid(hValid), .upper(upLim), .lower(loLim),
    .code(hCode), .stepSel(stSel), .rateSel(rtSel), .resSel(rsSel));
  awg_triangle_gen i_awg_triangle_gen (.sys_clk(sys_clk), .rst(rst),
    .generatorBeginCmd(begCmd), .generatorHaltCmd(hltCmd),
    .rampUpperLimit(upLim), .rampLowerLimit(loLim), .stepSel(stSel),
    .rateSel(rtSel), .resSel(rsSel), .peakDwellTime(dwell),
    .hostCodeValid(hValid), .hostCode(hCode), .polaritySwapEnable(swapReq),
    .dacCode(dCode), .dacCodeLoad(dLoad), .chopEnable(chop),
    .generatorActive(active), .hostCodeDropped(dropped));
  // Verdict and end of run
  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Compare one value
  task automatic chk(input string nm, input logic [23:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Wait for the next load pulse, counting cycles
  task automatic next_load(output logic [23:0] c, output int t);
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (dLoad !== 1'b1 && t < 40000);
    c = dCode;
  endtask : next_load
  // Host code taken while idle, chop follows request
  task automatic t_idle();
    i_awg_host_model.send(24'h0abcde);
    chk("idle code", 24'h0abcde, dCode);
    chk("idle load", 24'h1, {23'h0, dLoad});
    chk("idle chop", 24'h1, {23'h0, chop});
    @(negedge sys_clk);
    swapReq = 1'b0;
    @(negedge sys_clk);
    chk("chop off", 24'h0, {23'h0, chop});
    swapReq = 1'b1;
  endtask : t_idle
  // Full triangle with clamping at both ends, then halt
  task automatic t_ramp();
    logic [23:0] c;
    int t;
    logic [23:0] ex[7] = '{24'h001400, 24'h001800, 24'h00192c, 24'h00152c,
                           24'h00112c, 24'h001000, 24'h001400};
    int unsigned gd = awg_pkg::RATE_CYC_7 + dwell;
    i_awg_host_model.run(24'h001000, 24'h00192c, 3'h0, 3'h7, 2'h0);
    chk("start code", 24'h001000, dCode);
    chk("active", 24'h1, {23'h0, active});
    chk("run chop", 24'h0, {23'h0, chop});
    i_awg_host_model.send(24'h00aaaa);
    chk("dropped", 24'h1, {23'h0, dropped});
    chk("code kept", 24'h001000, dCode);
    foreach (ex[i]) begin
      next_load(c, t);
      chk("ramp code", ex[i], c);
      if (i == 1) chk("gap", 24'(awg_pkg::RATE_CYC_7), 24'(t));
      if (i == 3) chk("dwell gap", 24'(gd), 24'(t));
    end
    i_awg_host_model.halt();
    chk("halted", 24'h0, {23'h0, active});
    chk("held code", c, dCode);
  endtask : t_ramp
  // Zero dwell turns round on the clamping update
  task automatic t_flat();
    logic [23:0] c;
    int t;
    @(negedge sys_clk);
    dwell = 32'h0;
    i_awg_host_model.run(24'h001000, 24'h001800, 3'h0, 3'h7, 2'h0);
    next_load(c, t);
    chk("flat up", 24'h001400, c);
    next_load(c, t);
    chk("flat top", 24'h001800, c);
    next_load(c, t);
    chk("flat turn", 24'h001400, c);
    chk("flat gap", 24'(awg_pkg::RATE_CYC_7), 24'(t));
    i_awg_host_model.halt();
  endtask : t_flat
  // Step size per resolution and update period for rate codes 4 to 7
  task automatic t_mix();
    logic [23:0] c;
    int t;
    int unsigned cy[4] = '{awg_pkg::RATE_CYC_4, awg_pkg::RATE_CYC_5,
                           awg_pkg::RATE_CYC_6, awg_pkg::RATE_CYC_7};
    for (int i = 0; i < 4; i++) begin
      i_awg_host_model.run(24'h001000, 24'h00f000, 3'h3, 3'(4 + i),
                           2'(i % 3));
      next_load(c, t);
      chk("step", 24'h001000 + (24'h002000 >> (2 * (i % 3))), c);
      next_load(c, t);
      chk("rate gap", 24'(cy[i]), 24'(t));
      i_awg_host_model.halt();
    end
  endtask : t_mix
  // Cycle ceiling against hangs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    t_idle();
    t_ramp();
    t_flat();
    t_mix();
    close_out();
  end
endmodule : awg_triangle_gen_tb
